/* common/flash_sector_protection_consts.vh */
// constants for the flash sector protection block
`ifndef FLASH_SECTOR_PROTECTION_CONSTS_VH
`define FLASH_SECTOR_PROTECTION_CONSTS_VH

// ============================================================
// command bytes
`define CMD_PREFIX0 8'h3d
`define CMD_PREFIX1 8'h2a
`define CMD_PREFIX2 8'h7f
`define CMD_PROT_ENABLE 8'ha9
`define CMD_PROT_DISABLE 8'h9a
`define CMD_MAP_ERASE 8'hcf
`define CMD_MAP_PROGRAM 8'hfc

// ============================================================
// protection map layout and values
`define MAP_RESET 32'h00000000
`define MAP_ERASED 32'hffffffff
`define MAP_BYTES 4
`define SEC0A_FIELD_HI 7
`define SEC0A_FIELD_LO 6
`define SEC0B_FIELD_HI 5
`define SEC0B_FIELD_LO 4
`define REGION_COUNT 5

// ============================================================
// timing; times in ns, cycle counts derived at 100 MHz
`define CLK_PERIOD_NS 10
`define GUARD_ASSERT_DELAY_NS 1000
`define GUARD_RELEASE_DELAY_NS 1000
`define MAP_ERASE_TIME_NS 2000000
`define MAP_PROGRAM_TIME_NS 2000000
`define GUARD_ASSERT_CYCLES (`GUARD_ASSERT_DELAY_NS / `CLK_PERIOD_NS)
`define GUARD_RELEASE_CYCLES (`GUARD_RELEASE_DELAY_NS / `CLK_PERIOD_NS)
`define MAP_ERASE_CYCLES \
	((`MAP_ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAP_PROGRAM_CYCLES \
	((`MAP_PROGRAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_WIDTH 24
`define FILTER_WIDTH 8

`endif

/* rtl/protection_map_store.v */
// four-byte protection map storage with registered read data
`timescale 1ns/10ps
`include "flash_sector_protection_consts.vh"

module protection_map_store (
	input wire clk,
	input wire srst,
	input wire we,
	input wire [31:0] wdata,
	output reg [31:0] rdata_q
);

	// ============================================================
	// storage
	// delivered map image, split into byte lanes below
	localparam [31:0] MAP_INIT = `MAP_RESET;
	reg [7:0] mem_q [0:`MAP_BYTES-1];
	genvar i;

	// each byte cell loads its lane; delivered state is all zero
	generate
		for (i = 0; i < `MAP_BYTES; i = i + 1) begin : g_byte
			always @(posedge clk) begin
				if (srst) begin
					mem_q[i] <= MAP_INIT[8*i +: 8]; // RQ15
				end else if (we) begin
					mem_q[i] <= wdata[8*i+7:8*i];
				end
			end
		end
	endgenerate

	// read port comes out of a register, one cycle behind the cells
	always @(posedge clk) begin
		if (srst) begin
			rdata_q <= `MAP_RESET;
		end else begin
			rdata_q <= {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
		end
	end

endmodule // protection_map_store

/* rtl/flash_sector_protection.v */
// sector protection logic: serial command decode, guard pin, map
`timescale 1ns/10ps
`include "flash_sector_protection_consts.vh"

// Overview of operation
// RQ1 - 3D 2A 7F A9 then chip select rise sets software protection
// RQ2 - 3D 2A 7F 9A then chip select rise clears software protection
// RQ3 - disable command ignored while write guard is asserted
// RQ4 - write guard input idles deasserted (high) when not driven
// RQ5 - software protection enable is clear after reset
// RQ6 - guard asserted refuses map changes and protected sector changes
// RQ7 - asserting guard turns protection on within assert delay
// RQ8 - releasing guard drops protection after delay unless enabled
// RQ9 - enable command keeps protection on after guard release
// RQ10 - guard input filtered so short glitches are ignored
// RQ11 - four map bytes, byte n selects sector n
// RQ12 - host erases map before programming it
// RQ13 - sectors 1 to 3: FF protected, 00 unprotected
// RQ14 - sector 0: bits 7:6 guard 0a, bits 5:4 guard 0b
// RQ15 - map holds all zero in delivered state
// RQ16 - 3D 2A 7F CF starts self-timed map erase, busy meanwhile
// RQ17 - map erase accepted either way, sets every byte to FF
// RQ18 - status shows protection enabled by command or guard pin
// RQ19 - 3D 2A 7F FC plus four data bytes programs map, wraps
// RQ20 - chip erase spares protected sectors
// RQ21 - effective protection is software OR guard, blocks flagged
module flash_sector_protection #(
	parameter [`TIMER_WIDTH-1:0] MAP_ERASE_CYCLES = `MAP_ERASE_CYCLES,
	parameter [`TIMER_WIDTH-1:0] MAP_PROGRAM_CYCLES = `MAP_PROGRAM_CYCLES
) (
	input wire clk,
	input wire srst,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire guard_n,
	input wire op_req,
	input wire [1:0] op_sector,
	input wire op_sub0b,
	output reg op_done_q,
	output reg op_allow_q,
	output reg [`REGION_COUNT-1:0] erase_mask_q,
	output reg prot_enabled_q,
	output reg busy_q,
	output reg cmd_ignored_q,
	output reg [31:0] map_q
);

	// ============================================================
	// constants and helpers
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_ERASE = 2'd1;
	localparam [1:0] ST_PROGRAM = 2'd2;
	localparam integer ASSERT_INT = `GUARD_ASSERT_CYCLES;
	localparam integer RELEASE_INT = `GUARD_RELEASE_CYCLES;
	localparam [`FILTER_WIDTH-1:0] ASSERT_CYC =
		ASSERT_INT[`FILTER_WIDTH-1:0];
	localparam [`FILTER_WIDTH-1:0] RELEASE_CYC =
		RELEASE_INT[`FILTER_WIDTH-1:0];

	// region 0 = 0a, 1 = 0b, 2..4 = sectors 1..3
	function region_flagged;
		input [31:0] map;
		input [2:0] region;
		begin
			case (region)
				3'd0: region_flagged =
					&map[`SEC0A_FIELD_HI:`SEC0A_FIELD_LO]; // RQ14
				3'd1: region_flagged =
					&map[`SEC0B_FIELD_HI:`SEC0B_FIELD_LO]; // RQ14
				3'd2: region_flagged = |map[15:8]; // RQ13
				3'd3: region_flagged = |map[23:16]; // RQ13
				3'd4: region_flagged = |map[31:24]; // RQ13
				default: region_flagged = 1'b1;
			endcase
		end
	endfunction

	// ============================================================
	// pin synchronisers
	reg cs_n_s1_q, cs_n_s2_q, cs_n_prev_q;
	reg sck_s1_q, sck_s2_q, sck_prev_q;
	reg si_s1_q, si_s2_q;
	reg guard_n_s1_q, guard_n_s2_q;

	// two flops per pin; guard and select idle high
	always @(posedge clk) begin
		if (srst) begin
			cs_n_s1_q <= 1'b1;
			cs_n_s2_q <= 1'b1;
			cs_n_prev_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_prev_q <= 1'b0;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
			guard_n_s1_q <= 1'b1; // RQ4
			guard_n_s2_q <= 1'b1; // RQ4
		end else begin
			cs_n_s1_q <= cs_n;
			cs_n_s2_q <= cs_n_s1_q;
			cs_n_prev_q <= cs_n_s2_q;
			sck_s1_q <= sck;
			sck_s2_q <= sck_s1_q;
			sck_prev_q <= sck_s2_q;
			si_s1_q <= si;
			si_s2_q <= si_s1_q;
			guard_n_s1_q <= guard_n;
			guard_n_s2_q <= guard_n_s1_q;
		end
	end

	wire cs_fall = cs_n_prev_q & ~cs_n_s2_q;
	wire cs_rise = ~cs_n_prev_q & cs_n_s2_q;
	// mode 0 and 3 both sample on the rising serial clock edge
	wire sck_rise = sck_s2_q & ~sck_prev_q & ~cs_n_s2_q;

	// ============================================================
	// guard filter
	reg guard_q;
	reg [`FILTER_WIDTH-1:0] filt_cnt_q;
	wire guard_raw = ~guard_n_s2_q;
	wire [`FILTER_WIDTH-1:0] filt_lim = guard_q ? RELEASE_CYC : ASSERT_CYC;

	// the level must differ for a full delay before it is taken;
	// a glitch shorter than that restarts the count
	always @(posedge clk) begin
		if (srst) begin
			guard_q <= 1'b0;
			filt_cnt_q <= {`FILTER_WIDTH{1'b0}};
		end else if (guard_raw != guard_q) begin
			if (filt_cnt_q >= filt_lim - 1'b1) begin
				guard_q <= guard_raw; // RQ7 RQ8
				filt_cnt_q <= {`FILTER_WIDTH{1'b0}};
			end else begin
				filt_cnt_q <= filt_cnt_q + 1'b1; // RQ10
			end
		end else begin
			filt_cnt_q <= {`FILTER_WIDTH{1'b0}}; // RQ10
		end
	end

	// ============================================================
	// serial command receiver
	reg [6:0] shift_q;
	reg [2:0] bit_cnt_q;
	reg [2:0] byte_cnt_q;
	reg prefix_ok_q;
	reg opc_valid_q;
	reg [7:0] opcode_q;
	reg [1:0] data_idx_q;
	reg [31:0] prog_buf_q;
	wire [7:0] rx_byte = {shift_q, si_s2_q};
	wire byte_done = sck_rise & (bit_cnt_q == 3'd7);

	// bytes shift in msb first; counts restart at each select
	always @(posedge clk) begin
		if (srst || cs_fall) begin
			shift_q <= 7'h00;
			bit_cnt_q <= 3'd0;
			byte_cnt_q <= 3'd0;
			prefix_ok_q <= 1'b0;
			opc_valid_q <= 1'b0;
			opcode_q <= 8'h00;
			data_idx_q <= 2'd0;
			prog_buf_q <= `MAP_ERASED;
		end else if (sck_rise) begin
			shift_q <= rx_byte[6:0];
			bit_cnt_q <= bit_cnt_q + 3'd1;
			if (byte_done) begin
				if (byte_cnt_q != 3'd4) begin
					byte_cnt_q <= byte_cnt_q + 3'd1;
				end
				case (byte_cnt_q)
					3'd0: prefix_ok_q <= (rx_byte == `CMD_PREFIX0);
					3'd1: prefix_ok_q <= prefix_ok_q &
						(rx_byte == `CMD_PREFIX1);
					3'd2: prefix_ok_q <= prefix_ok_q &
						(rx_byte == `CMD_PREFIX2);
					3'd3: begin
						opcode_q <= rx_byte;
						opc_valid_q <= prefix_ok_q;
					end
					default: begin
						// data bytes wrap round to location 0
						if (opc_valid_q &&
								opcode_q == `CMD_MAP_PROGRAM) begin
							prog_buf_q[8*data_idx_q +: 8] <= rx_byte; // RQ19
							data_idx_q <= data_idx_q + 2'd1; // RQ19
						end
					end
				endcase
			end
		end
	end

	// a command counts only if select rises on a byte boundary
	wire cmd_go = cs_rise & opc_valid_q & (bit_cnt_q == 3'd0);

	// ============================================================
	// protection state and self-timed map operations
	reg sw_en_q;
	reg [1:0] state_q;
	reg [`TIMER_WIDTH-1:0] timer_q;
	reg [31:0] pend_map_q;
	reg map_we_q;
	wire [31:0] map_rd;
	wire prot_active = sw_en_q | guard_q; // RQ21

	// commands are taken only when idle; a busy device ignores them
	always @(posedge clk) begin
		if (srst) begin
			sw_en_q <= 1'b0; // RQ5
			state_q <= ST_IDLE;
			timer_q <= {`TIMER_WIDTH{1'b0}};
			pend_map_q <= `MAP_RESET;
			map_we_q <= 1'b0;
			cmd_ignored_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			map_we_q <= 1'b0;
			cmd_ignored_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (cmd_go) begin
						case (opcode_q)
							`CMD_PROT_ENABLE: begin
								sw_en_q <= 1'b1; // RQ1 RQ9
							end
							`CMD_PROT_DISABLE: begin
								if (guard_q) begin
									cmd_ignored_q <= 1'b1; // RQ3
								end else begin
									sw_en_q <= 1'b0; // RQ2 RQ9
								end
							end
							`CMD_MAP_ERASE: begin
								if (guard_q) begin
									cmd_ignored_q <= 1'b1; // RQ6
								end else begin
									// accepted whatever sw_en_q holds
									pend_map_q <= `MAP_ERASED; // RQ17
									timer_q <= MAP_ERASE_CYCLES; // RQ16
									state_q <= ST_ERASE;
									busy_q <= 1'b1; // RQ16
								end
							end
							`CMD_MAP_PROGRAM: begin
								if (guard_q) begin
									cmd_ignored_q <= 1'b1; // RQ6
								end else begin
									// cells only clear bits; needs prior erase
									pend_map_q <= map_rd & prog_buf_q; // RQ12
									timer_q <= MAP_PROGRAM_CYCLES;
									state_q <= ST_PROGRAM;
									busy_q <= 1'b1;
								end
							end
							default: begin
								cmd_ignored_q <= 1'b1;
							end
						endcase
					end
				end
				ST_ERASE, ST_PROGRAM: begin
					if (timer_q <= {{(`TIMER_WIDTH-1){1'b0}}, 1'b1}) begin
						map_we_q <= 1'b1; // RQ11
						state_q <= ST_IDLE;
						busy_q <= 1'b0; // RQ16
					end else begin
						timer_q <= timer_q - 1'b1;
					end
					if (cmd_go) begin
						cmd_ignored_q <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	protection_map_store u_map (
		.clk(clk),
		.srst(srst),
		.we(map_we_q),
		.wdata(pend_map_q),
		.rdata_q(map_rd)
	);

	// ============================================================
	// array side checks and status
	wire [2:0] op_region = (op_sector == 2'd0) ? {2'b00, op_sub0b} :
		{1'b0, op_sector} + 3'd1;
	wire [`REGION_COUNT-1:0] region_safe;
	genvar r;

	// a region may be altered unless flagged while protection is on
	generate
		for (r = 0; r < `REGION_COUNT; r = r + 1) begin : g_region
			localparam integer RI = r;
			localparam [2:0] RID = RI[2:0];
			assign region_safe[r] = ~(prot_active &
				region_flagged(map_rd, RID)); // RQ20 RQ21
		end
	endgenerate

	// answers to the array engines and status bits, all registered
	always @(posedge clk) begin
		if (srst) begin
			op_done_q <= 1'b0;
			op_allow_q <= 1'b0;
			erase_mask_q <= {`REGION_COUNT{1'b0}};
			prot_enabled_q <= 1'b0;
			map_q <= `MAP_RESET;
		end else begin
			op_done_q <= op_req;
			op_allow_q <= op_req & ~(prot_active &
				region_flagged(map_rd, op_region)); // RQ6 RQ21
			erase_mask_q <= region_safe; // RQ20
			prot_enabled_q <= prot_active; // RQ18
			map_q <= map_rd;
		end
	end

endmodule // flash_sector_protection

/* tb/spi_host_model.sv */
// host side serial master model: chip select, serial clock and data
`timescale 1ns/10ps
// ============================================================
// mode 0 frames; the serial clock stands low between frames
module spi_host_model (
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// sends n bytes from the top of d, msb first, data moved while sck low
	task automatic send(input logic [63:0] d, input int n);
		int i;
		cs_n <= 1'b0;
		for (i = 0; i < 8 * n; i++) begin
			#62.5 sck <= 1'b0;
			si <= d[63 - i];
			#62.5 sck <= 1'b1;
		end
		#62.5 sck <= 1'b0;
		#62.5 cs_n <= 1'b1;
		si <= ~si; // released line must not keep its last bit
		#600;
	endtask
endmodule // spi_host_model

/* tb/flash_sector_protection_asserts.sv */
// concurrent checks on the ports of the sector protection block
`timescale 1ns/10ps
`include "flash_sector_protection_consts.vh"
module flash_sector_protection_asserts #(
	parameter [`TIMER_WIDTH-1:0] MAP_ERASE_CYCLES = 300,
	parameter [`TIMER_WIDTH-1:0] MAP_PROGRAM_CYCLES = 300
) (
	input wire clk,
	input wire srst,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire guard_n,
	input wire op_req,
	input wire [1:0] op_sector,
	input wire op_sub0b,
	input wire op_done_q,
	input wire op_allow_q,
	input wire [`REGION_COUNT-1:0] erase_mask_q,
	input wire prot_enabled_q,
	input wire busy_q,
	input wire cmd_ignored_q,
	input wire [31:0] map_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] low_cnt_q;
	logic [3:0] cs_age_q;
	logic [`TIMER_WIDTH-1:0] busy_cnt_q;
	logic cs_d1_q;
	// ============================================================
	// helper counters: guard low time, age of cs rise, busy length
	always @(posedge clk) begin
		cs_d1_q <= cs_n;
		low_cnt_q <= (srst || guard_n) ? 8'h00 :
			(low_cnt_q == 8'hff ? low_cnt_q : low_cnt_q + 8'h01);
		cs_age_q <= srst ? 4'hf : (cs_n && !cs_d1_q) ? 4'h0 :
			(cs_age_q == 4'hf ? cs_age_q : cs_age_q + 4'h1);
		busy_cnt_q <= (srst || !busy_q) ? '0 : busy_cnt_q + 1'b1;
	end
	// ============================================================
	// checks
	reset_clear_a: assert property (disable iff (1'b0) srst |=>
		!prot_enabled_q && !busy_q)
		else $error("outputs not clear after reset");
	op_answer_a: assert property (op_done_q == $past(op_req))
		else $error("op answer not one cycle after request");
	allow_done_a: assert property (op_allow_q |-> op_done_q)
		else $error("allow without answer");
	guard_on_a: assert property (low_cnt_q >= 8'd110 |-> prot_enabled_q)
		else $error("guard did not turn protection on");
	glitch_filter_a: assert property ($rose(prot_enabled_q) |->
		low_cnt_q >= 8'd95 || cs_age_q < 4'd12)
		else $error("protection rose without cause");
	guard_refuse_a: assert property (op_req && low_cnt_q >= 8'd110 &&
		op_sector != 2'd0 && map_q[op_sector * 8 +: 8] != 8'h00
		|=> !op_allow_q)
		else $error("flagged sector allowed under guard");
	open_allow_a: assert property (op_req && !prot_enabled_q ##1
		!prot_enabled_q |-> op_allow_q)
		else $error("op refused with protection off");
	mask_spare_a: assert property ((prot_enabled_q &&
		map_q[31:8] == 24'hffffff)[*2] |-> erase_mask_q[4:2] == 3'b000)
		else $error("chip erase mask includes protected sector");
	busy_len_a: assert property ($fell(busy_q) |->
		busy_cnt_q + 2 >= MAP_ERASE_CYCLES &&
		busy_cnt_q <= MAP_ERASE_CYCLES + 2)
		else $error("busy length wrong");
	refuse_time_a: assert property (cmd_ignored_q |-> cs_age_q < 4'd12)
		else $error("refusal not tied to a frame end");
	busy_cv: cover property ($rose(busy_q));
	ignore_cv: cover property (cmd_ignored_q);
	deny_cv: cover property (op_done_q && !op_allow_q);
endmodule // flash_sector_protection_asserts

/* tb/flash_sector_protection_tb.sv */
// self-checking bench for the sector protection block
`timescale 1ns/10ps
module flash_sector_protection_tb;
	logic clk, srst, cs_n, sck, si, guard_n, op_req, op_sub0b;
	logic [1:0] op_sector;
	logic op_done_q, op_allow_q, prot_enabled_q, busy_q, cmd_ignored_q;
	logic [4:0] erase_mask_q;
	logic [31:0] map_q;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	int ign_cnt = 0;
	int ign_base = 0;
	spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si));
	flash_sector_protection #(.MAP_ERASE_CYCLES(24'd300),
		.MAP_PROGRAM_CYCLES(24'd300)) dut (
		.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
		.guard_n(guard_n), .op_req(op_req), .op_sector(op_sector),
		.op_sub0b(op_sub0b), .op_done_q(op_done_q), .op_allow_q(op_allow_q),
		.erase_mask_q(erase_mask_q), .prot_enabled_q(prot_enabled_q),
		.busy_q(busy_q), .cmd_ignored_q(cmd_ignored_q), .map_q(map_q));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ============================================================
	// timeout and refusal catcher; the refusal is a one-cycle pulse
	always @(posedge clk) begin
		cyc++;
		if (cmd_ignored_q === 1'b1) ign_cnt++;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmd(input logic [7:0] b);
		host.send({24'h3d2a7f, b, 32'h0}, 4);
	endtask
	// asks whether a sector op may run and compares the answer
	task op(input logic [1:0] s, input logic sub, input logic exp);
		@(posedge clk) op_req <= 1'b1;
		op_sector <= s;
		op_sub0b <= sub;
		@(posedge clk) op_req <= 1'b0;
		#1 chk({op_done_q, op_allow_q}, {1'b1, exp});
	endtask
	task guard(input logic lvl, input int n);
		@(posedge clk) guard_n <= lvl;
		repeat (n) @(posedge clk);
	endtask
	task wait_idle;
		int k;
		for (k = 0; k < 500 && busy_q !== 1'b0; k++) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ============================================================
	// main sequence
	initial begin
		srst = 1'b1;
		guard_n = 1'b1;
		op_req = 1'b0;
		op_sector = 2'd0;
		op_sub0b = 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(prot_enabled_q, 0);
		chk(map_q, 32'h0);
		op(2'd2, 1'b0, 1'b1);
		cmd(8'ha9);
		chk(prot_enabled_q, 1);
		cmd(8'h9a);
		chk(prot_enabled_q, 0);
		// an unknown fourth byte must be refused and change nothing
		ign_base = ign_cnt;
		cmd(8'h55);
		chk({ign_cnt != ign_base, prot_enabled_q}, 2'b10);
		$display("test commands done");
		cmd(8'hcf);
		chk(busy_q, 1);
		wait_idle();
		chk(map_q, 32'hffffffff);
		op(2'd3, 1'b0, 1'b1);
		cmd(8'ha9);
		op(2'd3, 1'b0, 1'b0);
		// the map was erased above, so the program lands exactly
		host.send({24'h3d2a7f, 8'hfc, 32'hc000ff00}, 8);
		wait_idle();
		chk(map_q, 32'h00ff00c0);
		chk(erase_mask_q, 5'h16);
		op(2'd0, 1'b0, 1'b0);
		op(2'd0, 1'b1, 1'b1);
		op(2'd1, 1'b0, 1'b1);
		op(2'd2, 1'b0, 1'b0);
		cmd(8'h9a);
		$display("test map done");
		guard(1'b0, 300);
		chk(prot_enabled_q, 1);
		ign_base = ign_cnt;
		cmd(8'hcf);
		chk({ign_cnt != ign_base, busy_q}, 2'b10);
		op(2'd2, 1'b0, 1'b0);
		guard(1'b1, 300);
		chk(prot_enabled_q, 0);
		cmd(8'ha9);
		guard(1'b0, 300);
		ign_base = ign_cnt;
		cmd(8'h9a);
		chk(ign_cnt != ign_base, 1);
		guard(1'b1, 300);
		chk(prot_enabled_q, 1);
		cmd(8'h9a);
		chk(prot_enabled_q, 0);
		guard(1'b0, 50);
		guard(1'b1, 300);
		chk(prot_enabled_q, 0);
		$display("test guard done");
		// a reset in mid-run must drop a software enable again
		cmd(8'ha9);
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(prot_enabled_q, 0);
		chk(map_q, 32'h0);
		$display("test reset done");
		print_verdict();
	end
endmodule // flash_sector_protection_tb
bind flash_sector_protection flash_sector_protection_asserts #(
	.MAP_ERASE_CYCLES(MAP_ERASE_CYCLES),
	.MAP_PROGRAM_CYCLES(MAP_PROGRAM_CYCLES)) chk_i (
	.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
	.guard_n(guard_n), .op_req(op_req), .op_sector(op_sector),
	.op_sub0b(op_sub0b), .op_done_q(op_done_q), .op_allow_q(op_allow_q),
	.erase_mask_q(erase_mask_q), .prot_enabled_q(prot_enabled_q),
	.busy_q(busy_q), .cmd_ignored_q(cmd_ignored_q), .map_q(map_q));
